// *** hw/ecdma_defs.vh ***
`ifndef ECDMA_DEFS_VH
`define ECDMA_DEFS_VH

// ****************************************
// Register word indices (byte address = index * 4)
// ****************************************
`define IDX_EXC_COLL      6'h00
`define IDX_DMA_LONG      6'h01
`define IDX_BLOCK_STATUS  6'h02
`define ADDR_IDX_MSB      7
`define ADDR_IDX_LSB      2

// ****************************************
// Reset values
// ****************************************
`define RST_EXC_COLL      3'h0
`define RST_DMA_LONG      1'h0

// ****************************************
// excess_collision_control fields
// ****************************************
`define EXC_ACT_MSB       2
`define EXC_ACT_LSB       0
`define ACT_AUTO_RETRY    3'h6
`define ACT_AUTO_SKIP     3'h7
`define ACT_RESUME_RETRY  3'h2
`define ACT_RESUME_SKIP   3'h3
`define ACT_MANUAL_HI     2'h1

// ****************************************
// dma_and_long_packet_enable fields
// ****************************************
`define DMA_LFD_BIT       3
`define DMA_RD_BIT        1
`define DMA_WR_BIT        0

// ****************************************
// block_status fields
// ****************************************
`define STS_HALT_BIT      0

// ****************************************
// Limits and bus codes
// ****************************************
`define COLL_LIMIT        16
`define LONG_LIMIT        1792
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2

`endif

// *** hw/excess_coll_ctrl.v ***
`timescale 1ns/1ps
`include "ecdma_defs.vh"

module excess_coll_ctrl #(
    parameter COLL_LIMIT = `COLL_LIMIT
) (
    input  wire       i_clk,
    input  wire       i_nrst,
    input  wire [2:0] i_mode,
    input  wire       i_collision,
    input  wire       i_tx_done,
    input  wire       i_resume_retry,
    input  wire       i_resume_skip,
    output reg        o_retry,
    output reg        o_skip,
    output reg        o_halted,
    output reg        o_event
);

    localparam ST_RUN  = 1'b0;
    localparam ST_HALT = 1'b1;
    localparam integer LAST_I = COLL_LIMIT - 1;
    localparam [4:0]   LAST   = LAST_I[4:0];

    reg       state_r;
    reg [4:0] count_r;

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            state_r  <= ST_RUN;
            count_r  <= 5'h00;
            o_retry  <= 1'b0;
            o_skip   <= 1'b0;
            o_halted <= 1'b0;
            o_event  <= 1'b0;
        end else begin
            o_retry <= 1'b0;
            o_skip  <= 1'b0;
            o_event <= 1'b0;
            case (state_r)
                ST_RUN: begin
                    // Collision wins over a same-cycle done
                    if (i_collision) begin
                        if (count_r == LAST) begin
                            o_event <= 1'b1; // [RQ17]
                            count_r <= 5'h00;
                            if (i_mode[2:1] == `ACT_MANUAL_HI) begin
                                state_r  <= ST_HALT; // [RQ5]
                                o_halted <= 1'b1;
                            end else if (i_mode == `ACT_AUTO_SKIP) begin
                                o_skip <= 1'b1; // [RQ4]
                            end else begin
                                // Undefined codes fall back to retry
                                o_retry <= 1'b1; // [RQ3]
                            end
                        end else begin
                            count_r <= count_r + 5'h01; // [RQ17]
                        end
                    end else if (i_tx_done) begin
                        count_r <= 5'h00; // [RQ17]
                    end
                end
                ST_HALT: begin
                    // Resume pulses only act here, never remembered
                    if (i_resume_retry) begin
                        o_retry  <= 1'b1; // [RQ7]
                        o_halted <= 1'b0;
                        state_r  <= ST_RUN;
                    end else if (i_resume_skip) begin
                        o_skip   <= 1'b1; // [RQ8]
                        o_halted <= 1'b0;
                        state_r  <= ST_RUN;
                    end
                end
                default: begin
                    state_r <= ST_RUN;
                end
            endcase
        end
    end

endmodule

// *** hw/long_frame_filter.v ***
`timescale 1ns/1ps
`include "ecdma_defs.vh"

module long_frame_filter #(
    parameter LONG_LIMIT = `LONG_LIMIT
) (
    input  wire i_clk,
    input  wire i_nrst,
    input  wire i_drop_enable,
    input  wire i_frame_start,
    input  wire i_byte,
    output reg  o_drop
);

    localparam integer LAST_I = LONG_LIMIT - 1;
    localparam [10:0]  LAST   = LAST_I[10:0];

    reg [10:0] count_r;
    reg        done_r;

    always @(posedge i_clk) begin
        if (!i_nrst) begin
            count_r <= 11'h000;
            done_r  <= 1'b0;
            o_drop  <= 1'b0;
        end else begin
            o_drop <= 1'b0;
            if (i_frame_start) begin
                count_r <= 11'h000;
                done_r  <= 1'b0;
            end else if (i_byte && !done_r) begin
                // Saturate at the limit; later bytes do not matter
                if (count_r == LAST) begin
                    done_r <= 1'b1;
                    o_drop <= i_drop_enable; // [RQ9] [RQ10]
                end else begin
                    count_r <= count_r + 11'h001;
                end
            end
        end
    end

endmodule

// *** hw/collision_dma_control_regs.v ***
// Overview of operation
// [RQ1] Collision control bits 7..3 read zero
// [RQ2] Software writes zero to unused bits
// [RQ3] Code 110: auto retry after sixteen collisions
// [RQ4] Code 111: auto skip failed packet
// [RQ5] Code 01x: halt transmitter until resume write
// [RQ6] Resume acts only when written, each halt
// [RQ7] Writing 010 while halted retransmits packet
// [RQ8] Writing 011 while halted skips packet
// [RQ9] Drop enabled: reject frames of 1792+ bytes
// [RQ10] Drop disabled: long frames not rejected
// [RQ11] DMA bits 7..4 undefined, bit 2 zero
// [RQ12] Bit 1 enables DMA reads from receive buffer
// [RQ13] Bit 0 enables DMA writes to buffer
// [RQ14] Writing 00 to DMA enables clears end flag
// [RQ15] Software never sets both DMA enables
// [RQ16] PC card mode keeps DMA enables zero
// [RQ17] Sixteen consecutive collisions on one packet
//
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "ecdma_defs.vh"

module collision_dma_control_regs #(
    parameter COLL_LIMIT = `COLL_LIMIT,
    parameter LONG_LIMIT = `LONG_LIMIT
) (
    input  wire        I_CLK,
    input  wire        I_NRST,
    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    input  wire [7:0]  I_AWADDR,
    input  wire        I_AWVALID,
    output reg         O_AWREADY,
    input  wire [31:0] I_WDATA,
    input  wire [3:0]  I_WSTRB,
    input  wire        I_WVALID,
    output reg         O_WREADY,
    output reg  [1:0]  O_BRESP,
    output reg         O_BVALID,
    input  wire        I_BREADY,
    input  wire [7:0]  I_ARADDR,
    input  wire        I_ARVALID,
    output reg         O_ARREADY,
    output reg  [31:0] O_RDATA,
    output reg  [1:0]  O_RRESP,
    output reg         O_RVALID,
    input  wire        I_RREADY,
    // ****************************************
    // Transmit link controller
    // ****************************************
    input  wire        I_TX_COLLISION,
    input  wire        I_TX_DONE,
    output wire        O_TX_RETRY,
    output wire        O_TX_SKIP,
    output wire        O_TX_HALTED,
    output wire        O_SIXTEEN_COLLISION_EVENT,
    // ****************************************
    // Receive path
    // ****************************************
    input  wire        I_RX_FRAME_START,
    input  wire        I_RX_BYTE,
    output wire        O_RX_LONG_DROP,
    // ****************************************
    // DMA
    // ****************************************
    output reg         O_DMA_READ_ENABLE,
    output reg         O_DMA_WRITE_ENABLE,
    output reg         O_DMA_END_FLAG_CLEAR
);

    // ****************************************
    // Register state
    // ****************************************
    reg  [2:0]  exc_action_r;
    reg         long_drop_dis_r;
    reg         aw_held_r;
    reg         w_held_r;
    reg  [7:0]  awaddr_r;
    reg  [31:0] wdata_r;
    reg  [3:0]  wstrb_r;
    reg         resume_retry_r;
    reg         resume_skip_r;

    wire        halted;
    wire [5:0]  wr_idx;
    wire [5:0]  rd_idx;
    wire        do_write;
    wire        lane0;
    wire [7:0]  wbyte;
    reg  [31:0] rd_word;
    reg         rd_hit;
    reg         wr_hit;
    wire        wr_exc;
    wire        wr_dma;
    wire [2:0]  new_action;
    wire        resume_retry_nxt;
    wire        resume_skip_nxt;
    wire        clear_nxt;

    assign wr_idx   = awaddr_r[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
    assign rd_idx   = I_ARADDR[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
    assign do_write = aw_held_r && w_held_r && !O_BVALID;
    assign lane0    = wstrb_r[0];
    assign wbyte    = wdata_r[7:0];

    // ****************************************
    // Write strobes
    // ****************************************
    // Decoded once so stored fields and pulses agree
    assign wr_exc     = do_write && lane0 && (wr_idx == `IDX_EXC_COLL);
    assign wr_dma     = do_write && lane0 && (wr_idx == `IDX_DMA_LONG);
    assign new_action = wbyte[`EXC_ACT_MSB:`EXC_ACT_LSB];
    // Resume codes written while running are stored but never act
    assign resume_retry_nxt = wr_exc && halted
                              && (new_action == `ACT_RESUME_RETRY); // [RQ6] [RQ7]
    assign resume_skip_nxt  = wr_exc && halted
                              && (new_action == `ACT_RESUME_SKIP); // [RQ6] [RQ8]
    // Pulses on every write of 00, even when already clear
    assign clear_nxt        = wr_dma && !wbyte[`DMA_RD_BIT]
                              && !wbyte[`DMA_WR_BIT]; // [RQ14]

    // ****************************************
    // Write address and data capture
    // ****************************************
    // Either channel may arrive first; each is parked until the response
    // has been taken, so a second write cannot overtake the first.
    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            awaddr_r  <= 8'h00;
            wdata_r   <= 32'h00000000;
            wstrb_r   <= 4'h0;
            O_AWREADY <= 1'b1;
            O_WREADY  <= 1'b1;
        end else begin
            if (O_BVALID && I_BREADY) begin
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
                O_AWREADY <= 1'b1;
                O_WREADY  <= 1'b1;
            end else begin
                if (I_AWVALID && O_AWREADY) begin
                    aw_held_r <= 1'b1;
                    awaddr_r  <= I_AWADDR;
                    O_AWREADY <= 1'b0;
                end
                if (I_WVALID && O_WREADY) begin
                    w_held_r <= 1'b1;
                    wdata_r  <= I_WDATA;
                    wstrb_r  <= I_WSTRB;
                    O_WREADY <= 1'b0;
                end
            end
        end
    end

    // ****************************************
    // Write decode
    // ****************************************
    always @* begin
        case (wr_idx)
            `IDX_EXC_COLL:     wr_hit = 1'b1;
            `IDX_DMA_LONG:     wr_hit = 1'b1;
            `IDX_BLOCK_STATUS: wr_hit = 1'b1;
            default:           wr_hit = 1'b0;
        endcase
    end

    // ****************************************
    // Register writes and their side effects
    // ****************************************
    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            exc_action_r         <= `RST_EXC_COLL;
            long_drop_dis_r      <= `RST_DMA_LONG;
            O_DMA_READ_ENABLE    <= `RST_DMA_LONG;
            O_DMA_WRITE_ENABLE   <= `RST_DMA_LONG;
            O_DMA_END_FLAG_CLEAR <= 1'b0;
            resume_retry_r       <= 1'b0;
            resume_skip_r        <= 1'b0;
        end else begin
            // Single-cycle strobes, only ever after a fresh write
            O_DMA_END_FLAG_CLEAR <= clear_nxt; // [RQ14]
            resume_retry_r       <= resume_retry_nxt; // [RQ7]
            resume_skip_r        <= resume_skip_nxt; // [RQ8]
            if (wr_exc) begin
                // Unused high bits are not stored
                exc_action_r <= new_action; // [RQ2]
            end
            if (wr_dma) begin
                long_drop_dis_r    <= wbyte[`DMA_LFD_BIT];
                // Both enables are stored as written; software keeps
                // them exclusive and zero in card mode
                O_DMA_READ_ENABLE  <= wbyte[`DMA_RD_BIT]; // [RQ12] [RQ15] [RQ16]
                O_DMA_WRITE_ENABLE <= wbyte[`DMA_WR_BIT]; // [RQ13]
            end
        end
    end

    // ****************************************
    // Write response
    // ****************************************
    // Unmapped words answer SLVERR so a bad offset shows in software
    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            O_BVALID <= 1'b0;
            O_BRESP  <= `RESP_OKAY;
        end else if (do_write) begin
            O_BVALID <= 1'b1;
            O_BRESP  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        end else if (O_BVALID && I_BREADY) begin
            O_BVALID <= 1'b0;
        end
    end

    // ****************************************
    // Read decode
    // ****************************************
    always @* begin
        rd_word = 32'h00000000;
        rd_hit  = 1'b1;
        case (rd_idx)
            `IDX_EXC_COLL: begin
                // Upper bits stay zero
                rd_word[`EXC_ACT_MSB:`EXC_ACT_LSB] = exc_action_r; // [RQ1]
            end
            `IDX_DMA_LONG: begin
                // Undefined upper nibble reads zero; bit 2 always zero
                rd_word[`DMA_LFD_BIT] = long_drop_dis_r; // [RQ11]
                rd_word[`DMA_RD_BIT]  = O_DMA_READ_ENABLE;
                rd_word[`DMA_WR_BIT]  = O_DMA_WRITE_ENABLE;
            end
            `IDX_BLOCK_STATUS: begin
                // Lets software spot a manual halt by polling
                rd_word[`STS_HALT_BIT] = halted;
            end
            default: begin
                // Unmapped index: SLVERR with zero data
                rd_hit = 1'b0;
            end
        endcase
    end

    // ****************************************
    // Read channel
    // ****************************************
    // Data are captured at the address handshake and held until taken
    always @(posedge I_CLK) begin
        if (!I_NRST) begin
            O_ARREADY <= 1'b1;
            O_RVALID  <= 1'b0;
            O_RDATA   <= 32'h00000000;
            O_RRESP   <= `RESP_OKAY;
        end else begin
            if (O_RVALID && I_RREADY) begin
                O_RVALID  <= 1'b0;
                O_ARREADY <= 1'b1;
            end else if (I_ARVALID && O_ARREADY) begin
                O_ARREADY <= 1'b0;
                O_RVALID  <= 1'b1;
                O_RDATA   <= rd_word;
                O_RRESP   <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
            end
        end
    end

    // ****************************************
    // Excess collision handling
    // ****************************************
    // Count and halt state live here; only pulses and the halt level leave
    excess_coll_ctrl #(
        .COLL_LIMIT (COLL_LIMIT)
    ) u_coll (
        .i_clk          (I_CLK),
        .i_nrst         (I_NRST),
        .i_mode         (exc_action_r),
        .i_collision    (I_TX_COLLISION),
        .i_tx_done      (I_TX_DONE),
        .i_resume_retry (resume_retry_r),
        .i_resume_skip  (resume_skip_r),
        .o_retry        (O_TX_RETRY),
        .o_skip         (O_TX_SKIP),
        .o_halted       (halted),
        .o_event        (O_SIXTEEN_COLLISION_EVENT)
    );

    assign O_TX_HALTED = halted;

    // ****************************************
    // Long frame removal
    // ****************************************
    // Removal off never drops, however long the frame
    long_frame_filter #(
        .LONG_LIMIT (LONG_LIMIT)
    ) u_long (
        .i_clk         (I_CLK),
        .i_nrst        (I_NRST),
        .i_drop_enable (!long_drop_dis_r),
        .i_frame_start (I_RX_FRAME_START),
        .i_byte        (I_RX_BYTE),
        .o_drop        (O_RX_LONG_DROP)
    );

endmodule

// *** dv/collision_dma_control_regs_checker.sv ***
`timescale 1ns/1ps
module collision_dma_control_regs_checker #(
    parameter COLL_LIMIT = 16,
    parameter LONG_LIMIT = 1792
) (
    input wire        I_CLK, I_NRST, I_ARVALID, O_ARREADY, O_RVALID, O_BVALID, I_BREADY,
    input wire [31:0] O_RDATA,
    input wire        O_AWREADY, O_TX_RETRY, O_TX_SKIP, O_TX_HALTED,
    input wire        O_SIXTEEN_COLLISION_EVENT, O_RX_LONG_DROP, O_DMA_READ_ENABLE,
    input wire        O_DMA_WRITE_ENABLE, O_DMA_END_FLAG_CLEAR
);
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    // ****
    // Sequences
    // ****
    sequence s_rd_take; I_ARVALID && O_ARREADY; endsequence
    sequence s_resume; $past(O_TX_HALTED) && !O_TX_HALTED; endsequence
    sequence s_dma_off; !O_DMA_READ_ENABLE && !O_DMA_WRITE_ENABLE; endsequence
    // ****
    // Properties
    // ****
    chk_rd_answer: assert property (s_rd_take |=> O_RVALID && !O_ARREADY)
        else $error("read answer not in next cycle");
    chk_rd_upper: assert property (O_RVALID |-> O_RDATA[31:8] == 24'h000000)
        else $error("read data upper bits not zero");
    chk_b_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID && !O_AWREADY)
        else $error("write response dropped early");
    chk_halt_rise: assert property ($rose(O_TX_HALTED) |-> O_SIXTEEN_COLLISION_EVENT)
        else $error("halt without sixteenth collision");
    chk_halt_hold: assert property (O_TX_HALTED && !O_BVALID |=> O_TX_HALTED)
        else $error("halt left without resume write");
    chk_retry_cause: assert property (O_TX_RETRY |-> O_SIXTEEN_COLLISION_EVENT or s_resume)
        else $error("retry without cause");
    chk_skip_cause: assert property (O_TX_SKIP |-> O_SIXTEEN_COLLISION_EVENT or s_resume)
        else $error("skip without cause");
    chk_act_excl: assert property (O_SIXTEEN_COLLISION_EVENT |=> !O_TX_RETRY && !O_TX_SKIP)
        else $error("action repeated after event");
    chk_end_clear: assert property (O_DMA_END_FLAG_CLEAR |-> s_dma_off ##0 $rose(O_BVALID))
        else $error("end flag clear without 00 write");
    chk_drop_once: assert property (O_RX_LONG_DROP |=> !O_RX_LONG_DROP)
        else $error("long drop longer than one cycle");
endmodule

// *** dv/host_bus_model.sv ***
`timescale 1ns/1ps
// ****
// Host processor on the register bus
// ****
module host_bus_model (
    input  wire        i_clk,
    output reg  [7:0]  o_awaddr,
    output reg         o_awvalid,
    input  wire        i_awready,
    output reg  [31:0] o_wdata,
    output reg  [3:0]  o_wstrb,
    output reg         o_wvalid,
    input  wire        i_wready,
    input  wire [1:0]  i_bresp,
    input  wire        i_bvalid,
    output reg         o_bready,
    output reg  [7:0]  o_araddr,
    output reg         o_arvalid,
    input  wire        i_arready,
    input  wire [31:0] i_rdata,
    input  wire [1:0]  i_rresp,
    input  wire        i_rvalid,
    output reg         o_rready
);
    initial begin
        {o_awvalid, o_wvalid, o_bready, o_arvalid, o_rready} = 5'h00;
        {o_awaddr, o_araddr, o_wstrb, o_wdata} = 52'h0;
    end
    task wr(input [7:0] a, input [7:0] d, output [1:0] r);
        reg aw_ok;
        reg w_ok;
        begin
            if (a == 8'h04 && d[1:0] == 2'h3) d[1:0] = 2'h2;
            @(posedge i_clk);
            o_awaddr  <= a;
            o_wdata   <= {24'h000000, d};
            o_wstrb   <= 4'h1;
            o_awvalid <= 1'b1;
            o_wvalid  <= 1'b1;
            aw_ok = 1'b0;
            w_ok = 1'b0;
            while (!(aw_ok && w_ok)) begin
                @(posedge i_clk);
                if (o_awvalid && i_awready) begin
                    aw_ok = 1'b1;
                    o_awvalid <= 1'b0;
                end
                if (o_wvalid && i_wready) begin
                    w_ok = 1'b1;
                    o_wvalid <= 1'b0;
                end
            end
            o_bready <= 1'b1;
            @(posedge i_clk);
            while (i_bvalid !== 1'b1) @(posedge i_clk);
            r = i_bresp;
            o_bready <= 1'b0;
        end
    endtask
    task rd(input [7:0] a, output [31:0] d, output [1:0] r);
        begin
            @(posedge i_clk);
            o_araddr  <= a;
            o_arvalid <= 1'b1;
            @(posedge i_clk);
            while (i_arready !== 1'b1) @(posedge i_clk);
            o_arvalid <= 1'b0;
            o_rready  <= 1'b1;
            @(posedge i_clk);
            while (i_rvalid !== 1'b1) @(posedge i_clk);
            d = i_rdata;
            r = i_rresp;
            o_rready <= 1'b0;
        end
    endtask
endmodule

// *** dv/collision_dma_control_regs_tb.sv ***
`timescale 1ns/1ps
module collision_dma_control_regs_tb;
    localparam LONG_N = 8;
    localparam P_COL = 0, P_DONE = 1, P_FST = 2, P_FBY = 3;
    reg         clk, nrst, col, done, fst, fby;
    wire [7:0]  awaddr, araddr;
    wire [31:0] wdata, rdata;
    wire [3:0]  wstrb;
    wire [1:0]  bresp, rresp;
    wire        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
    wire        rvalid, rready, retry, skip, halted, ev, drop, rden, wren, clr;
    integer     fail_count, n_compared, n_ev, n_rt, n_sk, n_dr, n_cl;

    collision_dma_control_regs #(.LONG_LIMIT(LONG_N)) u_collision_dma_control_regs (
        .I_CLK(clk), .I_NRST(nrst), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
        .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
        .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
        .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
        .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready), .I_TX_COLLISION(col),
        .I_TX_DONE(done), .O_TX_RETRY(retry), .O_TX_SKIP(skip), .O_TX_HALTED(halted),
        .O_SIXTEEN_COLLISION_EVENT(ev), .I_RX_FRAME_START(fst), .I_RX_BYTE(fby),
        .O_RX_LONG_DROP(drop), .O_DMA_READ_ENABLE(rden), .O_DMA_WRITE_ENABLE(wren),
        .O_DMA_END_FLAG_CLEAR(clr));
    host_bus_model u_host_bus_model (
        .i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid), .i_awready(awready),
        .o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .i_wready(wready),
        .i_bresp(bresp), .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
        .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata), .i_rresp(rresp),
        .i_rvalid(rvalid), .o_rready(rready));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        {fail_count, n_compared, n_ev, n_rt, n_sk, n_dr, n_cl} = 0;
        repeat (20000) @(posedge clk);
        fail_count = fail_count + 1;
        print_verdict;
    end
    // Pulses are one cycle wide, so count them rather than poll
    always @(posedge clk) begin
        if (ev === 1'b1) n_ev = n_ev + 1;
        if (retry === 1'b1) n_rt = n_rt + 1;
        if (skip === 1'b1) n_sk = n_sk + 1;
        if (drop === 1'b1) n_dr = n_dr + 1;
        if (clr === 1'b1) n_cl = n_cl + 1;
    end
    // ****
    // Tasks
    // ****
    task chk(input [8*8:1] nm, input [31:0] e, input [31:0] g);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("wrong value %0s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task wrc(input [7:0] a, input [7:0] d, input [1:0] er);
        reg [1:0] r;
        begin
            u_host_bus_model.wr(a, d, r);
            chk("bresp", er, r);
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e, input [1:0] er);
        reg [31:0] d;
        reg [1:0]  r;
        begin
            u_host_bus_model.rd(a, d, r);
            chk("rdata", e, d);
            chk("rresp", er, r);
        end
    endtask
    // Pins are picked by index: a task argument would be a copy
    task pulse(input integer w, input integer n);
        integer k;
        begin
            for (k = 0; k < 2 * n; k = k + 1) begin
                @(posedge clk);
                case (w)
                    P_COL:   col  <= !k[0];
                    P_DONE:  done <= !k[0];
                    P_FST:   fst  <= !k[0];
                    default: fby  <= !k[0];
                endcase
            end
        end
    endtask
    task cnt(input integer e, input integer r, input integer s);
        begin
            repeat (4) @(posedge clk);
            chk("events", e, n_ev);
            chk("retries", r, n_rt);
            chk("skips", s, n_sk);
        end
    endtask
    task frame(input integer n);
        begin
            pulse(P_FST, 1);
            pulse(P_FBY, n);
            repeat (4) @(posedge clk);
        end
    endtask
    task print_verdict;
        begin
            $display("compared %0d mismatches %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask
    // ****
    // Tests
    // ****
    initial begin
        {col, done, fst, fby, nrst} = 5'h00;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        rdc(8'h00, 32'h0, 2'h0);
        rdc(8'h04, 32'h0, 2'h0);
        rdc(8'h0C, 32'h0, 2'h2);
        wrc(8'h10, 8'h01, 2'h2);
        pulse(P_COL, 16);
        cnt(1, 1, 0);
        wrc(8'h00, 8'h06, 2'h0);
        pulse(P_COL, 16);
        cnt(2, 2, 0);
        pulse(P_COL, 15);
        pulse(P_DONE, 1);
        pulse(P_COL, 15);
        pulse(P_DONE, 1);
        cnt(2, 2, 0);
        wrc(8'h00, 8'h07, 2'h0);
        pulse(P_COL, 16);
        cnt(3, 2, 1);
        wrc(8'h00, 8'h02, 2'h0);
        pulse(P_COL, 20);
        cnt(4, 2, 1);
        rdc(8'h08, 32'h1, 2'h0);
        wrc(8'h00, 8'h02, 2'h0);
        cnt(4, 3, 1);
        chk("halted", 0, halted);
        pulse(P_COL, 16);
        wrc(8'h00, 8'h03, 2'h0);
        wrc(8'h00, 8'h03, 2'h0);
        cnt(5, 3, 2);
        pulse(P_COL, 16);
        @(posedge clk);
        chk("halted", 1, halted);
        wrc(8'h00, 8'h03, 2'h0);
        cnt(6, 3, 3);
        rdc(8'h00, 32'h3, 2'h0);
        wrc(8'h04, 8'h02, 2'h0);
        chk("rd_en", 1, rden);
        chk("wr_en", 0, wren);
        wrc(8'h04, 8'h01, 2'h0);
        chk("rd_en", 0, rden);
        chk("wr_en", 1, wren);
        chk("clears", 0, n_cl);
        wrc(8'h04, 8'h00, 2'h0);
        frame(LONG_N);
        frame(LONG_N - 1);
        chk("clears", 1, n_cl);
        chk("drops", 1, n_dr);
        wrc(8'h04, 8'h0A, 2'h0);
        rdc(8'h04, 32'h0A, 2'h0);
        frame(LONG_N + 1);
        chk("drops", 1, n_dr);
        print_verdict;
    end
endmodule

bind collision_dma_control_regs collision_dma_control_regs_checker #(
    .COLL_LIMIT(COLL_LIMIT), .LONG_LIMIT(LONG_LIMIT)) u_checker (
    .I_CLK(I_CLK), .I_NRST(I_NRST), .I_ARVALID(I_ARVALID), .O_ARREADY(O_ARREADY),
    .O_RVALID(O_RVALID), .O_BVALID(O_BVALID), .I_BREADY(I_BREADY), .O_RDATA(O_RDATA),
    .O_AWREADY(O_AWREADY), .O_TX_RETRY(O_TX_RETRY), .O_TX_SKIP(O_TX_SKIP),
    .O_TX_HALTED(O_TX_HALTED), .O_SIXTEEN_COLLISION_EVENT(O_SIXTEEN_COLLISION_EVENT),
    .O_RX_LONG_DROP(O_RX_LONG_DROP), .O_DMA_READ_ENABLE(O_DMA_READ_ENABLE),
    .O_DMA_WRITE_ENABLE(O_DMA_WRITE_ENABLE), .O_DMA_END_FLAG_CLEAR(O_DMA_END_FLAG_CLEAR));
